// [hw/crc8_msb.sv]
// Purpose: combinational CRC-8 over a data word, MSB first
// Assumes: polynomial and start value come from the package
// Notes:   no reflection and no final XOR
`timescale 1ns/1ps
module crc8_msb
  import ssi_fmt_pkg::*;
#(
  parameter int DATA_W = CRC_DW
)(
  input  wire logic [DATA_W-1:0] data,
  output logic      [CRC_W-1:0]  crc
);
  initial
  begin
    if (DATA_W < 1) $error("crc8_msb: DATA_W must be positive");
  end

  // Bitwise long division, one data bit per step
  always_comb
  begin
    logic fb;
    crc = CRC_INIT;
    fb  = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--)
    begin
      fb  = crc[CRC_W-1] ^ data[i];
      crc = {crc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00); // [RULE2]
    end
  end
endmodule

// [hw/ssi_fmt_pkg.sv]
// What this block does
// RULE1 - CRC variant sends 32 bits, CRC-8 of lower 24 bits in bits 31..24.
// RULE2 - CRC-8 uses polynomial 0x97, zero start, MSB first, no final XOR.
// RULE3 - CRC variant bit 23 is position valid, inverse of the fault indicator.
// RULE4 - Factory-zero flag at bit 22 (CRC) or bit 30 (time stamp).
// RULE5 - CRC variant bits 21..0 hold binary position, zero above resolution.
// RULE6 - Parity variant sends 30 bits: six zeros, then position in 23..2.
// RULE7 - Parity variant bit 1 is odd parity flag over bits 23..2.
// RULE8 - Parity variant bit 0 is alarm: 0 normal, 1 error.
// RULE9 - Gray variant sends 18 bits of Gray-coded position.
// RULE10 - Time-stamp variant bit 31 is position valid, inverse of fault.
// RULE11 - Time-stamp variant bits 29..11 hold 19-bit binary position.
// RULE12 - Bits 10..0 hold 1 us counter snapshot taken at measurement, wrapping.
// RULE13 - Idle: controller holds clock high, device holds data high.
// RULE14 - First falling edge starts a read; each rising edge shifts next bit, MSB first.
// RULE15 - After last edge, drive fault for 20 us update time, then data high.
// RULE16 - Controller clocks 100 kHz to 2 MHz and leaves gap over update time; the bench controller model clocks at 5 MHz (200 ns period).
// RULE17 - Whole message, check bits included, is captured when a read starts.
//
// Purpose: constants and types for the position message formatter
// Assumes: 40 MHz bus clock
// Notes:   offsets are byte addresses on a 32-bit AHB-Lite port
package ssi_fmt_pkg;
  // Timing
  localparam int CLK_NS          = 25;
  localparam int US_NS           = 1000;
  localparam int TICK_CYCLES     = US_NS / CLK_NS;
  localparam int TMU_NS          = 20000;
  localparam int TMU_CYCLES      = TMU_NS / CLK_NS;
  localparam int BIT_HOLD_NS     = 250;
  localparam int BIT_HOLD_CYCLES = (BIT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TS_WRAP_US      = 2047;

  // Message layout
  localparam int TS_W     = 11;
  localparam int POS_W    = 22;
  localparam int MSG_W    = 32;
  localparam int CNT_W    = 6;
  localparam int CRC_W    = 8;
  localparam int CRC_DW   = 24;
  localparam int LEN_CRC  = 32;
  localparam int LEN_PAR  = 30;
  localparam int LEN_GRAY = 18;
  localparam int LEN_TS   = 32;
  localparam int POS_TS_W = 19;
  localparam logic [7:0] CRC_POLY = 8'h97;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_POS  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_TIME = 8'h0C;
  localparam int CTRL_VAR_LSB   = 0;
  localparam int CTRL_FAULT_BIT = 4;
  localparam int CTRL_FZ_BIT    = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_UPD_BIT   = 1;
  localparam int STAT_TS_LSB    = 16;

  typedef enum logic [1:0] {crc_variant, parity_variant, gray_variant,
                            timestamp_variant} variant_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HOLD, ST_UPDATE} link_state_t;
endpackage

// [hw/ssi_position_message_formatter.sv]
// Purpose: formats position messages and shifts them out on a sync serial link
// Assumes: link clock is asynchronous and slow against hclk; software feeds
//          each measurement through the position register
// Notes:   registers on AHB-Lite, zero wait states, always OKAY
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module ssi_position_message_formatter
  import ssi_fmt_pkg::*;
#(
  parameter int RES_BITS = POS_W
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ssi_clk,
  output logic             ssi_data
);
  initial
  begin
    if (RES_BITS < 1 || RES_BITS > POS_W) $error("RES_BITS must be 1..22");
  end

  // Bus-side state
  logic [ADDR_W-1:0] addr_reg;
  logic              wr_pend_reg;
  logic [31:0]       ctrl_reg;
  logic [POS_W-1:0]  pos_reg;
  logic [TS_W-1:0]   ts_snap_reg;
  logic [31:0]       hrdata_reg;
  logic              pos_wr;
  logic              ctrl_wr;
  logic              rd_take;
  logic              wr_take;

  // Time base
  logic [5:0]        tick_cnt_reg;
  logic [TS_W-1:0]   ts_cnt_reg;

  // Link side
  logic              sclk_s1_reg;
  logic              sclk_s2_reg;
  logic              sclk_s3_reg;
  logic              sclk_rise;
  logic              sclk_fall;
  link_state_t       state_reg;
  logic [MSG_W-1:0]  shift_reg;
  logic [CNT_W-1:0]  bits_left_reg;
  logic [9:0]        timer_reg;
  logic              fault_cap_reg;
  logic              data_reg;

  // Message assembly
  variant_t          variant;
  logic              fault;
  logic              fzero;
  logic [POS_W-1:0]  pos_masked;
  logic [CRC_W-1:0]  crc_val;
  logic [CRC_DW-1:0] crc_data;
  logic [MSG_W-1:0]  msg;
  logic [CNT_W-1:0]  msg_len;

  // Word decode used by the write path only; reads decode in their own case
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFF_CTRL) || (a == OFF_POS) ||
                (a == OFF_STAT) || (a == OFF_TIME);
  endfunction

  // Gray encode of the low bits of a position
  function automatic logic [LEN_GRAY-1:0] to_gray(input logic [LEN_GRAY-1:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // Zero-wait slave: never stalls, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // Address phase qualifiers; only whole-word writes are honoured, reads of any size are taken
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite && (hsize == 3'b010);
  assign ctrl_wr = wr_pend_reg && (addr_reg == OFF_CTRL);
  assign pos_wr  = wr_pend_reg && (addr_reg == OFF_POS);

  // Latch write address until its data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg    <= 8'h00;
      wr_pend_reg <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= wr_take && is_mapped(haddr[ADDR_W-1:0]);
      if (wr_take)
        addr_reg <= haddr[ADDR_W-1:0];
    end
  end

  // Control register: variant, fault indicator, factory-zero flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl_reg <= {26'h000_0000, hwdata[CTRL_FZ_BIT], hwdata[CTRL_FAULT_BIT],
                   2'b00, hwdata[CTRL_VAR_LSB+1:CTRL_VAR_LSB]};
  end

  // A position write marks a measurement; time stamp snapped with it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pos_reg     <= '0;
      ts_snap_reg <= '0;
    end
    else if (pos_wr)
    begin
      pos_reg     <= hwdata[POS_W-1:0];
      ts_snap_reg <= ts_cnt_reg; // [RULE12]
    end
  end

  // Read data registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (rd_take)
    begin
      case (haddr[ADDR_W-1:0])
        OFF_CTRL: hrdata_reg <= ctrl_reg;
        OFF_POS:  hrdata_reg <= {10'h000, pos_reg};
        OFF_STAT: hrdata_reg <= {5'h00, ts_snap_reg, 14'h0000,
                                 state_reg == ST_UPDATE, state_reg != ST_IDLE};
        OFF_TIME: hrdata_reg <= {21'h00_0000, ts_cnt_reg};
        default:  hrdata_reg <= 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
  end

  // 1 us tick and free-running stamp counter; 11 bits wrap at 2047 naturally
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_reg <= '0;
      ts_cnt_reg   <= '0;
    end
    else if (tick_cnt_reg == 6'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= '0;
      ts_cnt_reg   <= (ts_cnt_reg == TS_W'(TS_WRAP_US)) ? '0 : ts_cnt_reg + 1'b1; // [RULE12]
    end
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end

  // Field sources
  assign variant    = variant_t'(ctrl_reg[CTRL_VAR_LSB+1:CTRL_VAR_LSB]);
  assign fault      = ctrl_reg[CTRL_FAULT_BIT];
  assign fzero      = ctrl_reg[CTRL_FZ_BIT];
  assign pos_masked = pos_reg & POS_W'((32'h1 << RES_BITS) - 1); // [RULE5] [RULE6]

  // Check bits over valid flag, zero flag and position. The CRC input is
  // built apart from the message word so the check bits never feed back
  // into their own source through the message assembly process.
  assign crc_data = {!fault, fzero, pos_masked}; // [RULE1]

  // Long division runs combinationally; 24 steps fit easily in one hclk
  crc8_msb #(
    .DATA_W (CRC_DW)
  ) u_crc (
    .data (crc_data),
    .crc  (crc_val)
  );

  // Message, right-aligned here; the sequencer left-aligns it on capture
  // so that the first bit out is always bit 31 of the shifter.
  // Unused upper bits stay zero, which the parity variant relies on
  // for its six leading zeros.
  always_comb
  begin
    msg     = '0;
    msg_len = CNT_W'(LEN_CRC);
    case (variant)
      crc_variant:
      begin
        msg[31:24] = crc_val;   // [RULE1] [RULE2]
        msg[22]   = fzero;      // [RULE4]
        msg[23]   = !fault;     // [RULE3]
        msg[21:0] = pos_masked; // [RULE5]
      end
      parity_variant:
      begin
        msg_len   = CNT_W'(LEN_PAR); // [RULE6]
        msg[23:2] = pos_masked;      // [RULE6]
        msg[1]    = ^pos_masked;     // [RULE7]
        msg[0]    = fault;           // [RULE8]
      end
      gray_variant:
      begin
        msg_len   = CNT_W'(LEN_GRAY);          // [RULE9]
        msg[17:0] = to_gray(pos_masked[17:0]); // [RULE9]
      end
      timestamp_variant:
      begin
        msg[31]    = !fault;                        // [RULE10]
        msg[30]    = fzero;                         // [RULE4]
        msg[29:11] = pos_masked[POS_TS_W-1:0];      // [RULE11]
        msg[10:0]  = ts_snap_reg;                   // [RULE12]
      end
      default: msg = '0;
    endcase
  end

  // Pin sync; idle level high so reset does not fake a falling edge.
  // A third stage only serves edge detection; logic never reads stage one,
  // so a metastable first stage cannot reach the sequencer.
  // Cost is two to three hclk of latency per link edge, which is small
  // against even the fastest link half period.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      sclk_s3_reg <= 1'b1;
    end
    else
    begin
      sclk_s1_reg <= ssi_clk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
    end
  end

  // Edges from synchronised copies only
  assign sclk_rise = sclk_s2_reg && !sclk_s3_reg;
  assign sclk_fall = !sclk_s2_reg && sclk_s3_reg;

  // Read-cycle sequencer
  // Idle waits for a falling link edge, shift moves one bit per rising
  // edge, hold keeps the last bit briefly, update drives the fault flag.
  // Edges outside idle and shift are ignored, so a controller that
  // restarts too early gets the fault level, not a torn message.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg     <= ST_IDLE;
      shift_reg     <= '0;
      bits_left_reg <= '0;
      timer_reg     <= '0;
      fault_cap_reg <= 1'b0;
      data_reg      <= 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          data_reg <= 1'b1; // [RULE13]
          if (sclk_fall) // [RULE14]
          begin
            // Snapshot keeps check bits consistent with the data shifted
            shift_reg     <= msg << (CNT_W'(MSG_W) - msg_len); // [RULE17]
            fault_cap_reg <= fault;                            // [RULE17]
            bits_left_reg <= msg_len;
            state_reg     <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (sclk_rise)
          begin
            data_reg      <= shift_reg[MSG_W-1]; // [RULE14]
            shift_reg     <= shift_reg << 1;
            bits_left_reg <= bits_left_reg - 1'b1;
            if (bits_left_reg == CNT_W'(1))
            begin
              timer_reg <= '0;
              state_reg <= ST_HOLD;
            end
          end
        end
        ST_HOLD:
        begin
          // Last bit kept for half a fastest clock period before the flag
          timer_reg <= timer_reg + 1'b1;
          if (timer_reg == 10'(BIT_HOLD_CYCLES - 1))
          begin
            data_reg  <= fault_cap_reg; // [RULE15]
            state_reg <= ST_UPDATE;
          end
        end
        ST_UPDATE:
        begin
          // Clock edges here are ignored; the controller must wait it out
          timer_reg <= timer_reg + 1'b1; // [RULE15]
          if (timer_reg == 10'(TMU_CYCLES - 1))
          begin
            data_reg  <= 1'b1; // [RULE15]
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          data_reg  <= 1'b1;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered data pin; no combinational path from the link clock
  // reaches it, so the line cannot glitch on a clock edge.
  assign ssi_data = data_reg;
endmodule

// [testbench/ssi_ctrl_model.sv]
// Purpose: position controller clocking the serial link
// Assumes: 200 ns link period; the bench starts each read on an hclk rise, so link edges land on hclk rises
// Notes:   takes each bit at the next rise, the last 150 ns after the final rise, inside the hold
`timescale 1ns/1ps
module ssi_ctrl_model (
  output logic      ssi_clk,
  input  wire logic ssi_data
);
  // Clock parked high between frames
  initial ssi_clk = 1'b1;
  // One read cycle of n bits, first fall starts it
  task automatic read_msg(input int n, output logic [31:0] m);
    m = '0;
    for (int k = 0; k < n; k++)
    begin
      #100 ssi_clk = 1'b0;
      #100 if (k > 0) m = {m[30:0], ssi_data};
      ssi_clk = 1'b1;
    end
    #150 m = {m[30:0], ssi_data};
  endtask
endmodule

// [testbench/ssi_fmt_chk.sv]
// Purpose: port checker for the position message formatter
// Assumes: link clock far slower than hclk
// Notes:   bound to every formatter instance
`timescale 1ns/1ps
module ssi_fmt_chk
  import ssi_fmt_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        ssi_clk,
  input wire logic        ssi_data
);
  logic       clk_q;
  logic [9:0] rise_age;
  logic       rd;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase taken
  assign rd = hsel && hready && htrans[1] && !hwrite;
  // Age since last link rise; saturates so idle looks long ago
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      clk_q    <= 1'b1;
      rise_age <= 10'h3ff;
    end
    else
    begin
      clk_q    <= ssi_clk;
      rise_age <= (ssi_clk && !clk_q) ? 10'h000 : rise_age + 10'(rise_age != 10'h3ff);
    end
  a_bus_no_wait: assert property (hsel && htrans[1] |-> hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (hsel && htrans[1] |=> !hresp)
    else $error("error response");
  a_unmapped_zero: assert property (rd && haddr[7:0] > OFF_TIME |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_time_upper: assert property (rd && haddr[7:0] == OFF_TIME |=> hrdata[31:11] == '0)
    else $error("time counter above 11 bits");
  a_stat_spare: assert property (rd && haddr[7:0] == OFF_STAT |=> hrdata[15:2] == '0)
    else $error("status spare bits set");
  a_bit_on_rise: assert property ($changed(ssi_data) && rise_age < 10'd100 |-> rise_age <= 10'd18)
    else $error("data moved away from a clock rise");
  a_update_len: assert property ($rose(ssi_data) && rise_age >= 10'd100 |-> rise_age >= 10'd790)
    else $error("update time too short");
  a_idle_high: assert property (rise_age >= 10'd860 |-> ssi_data)
    else $error("data not high when idle");
  a_fall_in_frame: assert property ($fell(ssi_data) |-> rise_age <= 10'd18)
    else $error("data fell outside a frame");
endmodule

bind ssi_position_message_formatter ssi_fmt_chk i_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .ssi_clk(ssi_clk), .ssi_data(ssi_data));

// [testbench/ssi_position_message_formatter_tb.sv]
// Purpose: self-checking bench for the position message formatter
// Assumes: zero-wait bus slave, RES_BITS cut to 20
// Notes:   position bits are don't-care while the fault flag is set
`timescale 1ns/1ps
module ssi_position_message_formatter_tb
  import ssi_fmt_pkg::*;
;
  localparam int RES = 20;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic        hreadyout, hresp, ssi_clk, ssi_data;
  int          failures = 0, tests_run = 0, cyc = 0;
  int          len[4] = '{LEN_CRC, LEN_PAR, LEN_GRAY, LEN_TS};
  logic [31:0] dc[4] = '{32'h003f_ffff, 32'h00ff_fffc, 32'h0003_ffff, 32'h3fff_f800};
  ssi_position_message_formatter #(.RES_BITS(RES)) i_ssi_position_message_formatter (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ssi_clk(ssi_clk),
    .ssi_data(ssi_data));
  ssi_ctrl_model i_ssi_ctrl_model (.ssi_clk(ssi_clk), .ssi_data(ssi_data));
  // Bus clock and a cycle count from reset release for time stamps
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (hresetn) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One single transfer; two idle cycles first so reads never hit a fresh write
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int t;
    t = 0;
    repeat (2) @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic [7:0] crc8(logic [23:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  function automatic logic [31:0] exp_msg(int v, logic [21:0] p, logic f, logic z,
                                          logic [10:0] ts);
    p = p & ((22'h1 << RES) - 22'h1);
    case (v)
      0: return {crc8({~f, z, p}), ~f, z, p};
      1: return {8'h00, p, ^p, f};
      2: return 32'(p[17:0] ^ (p[17:0] >> 1));
      default: return {~f, z, p[18:0], ts};
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, about three times the expected third of a millisecond
  initial
  begin
    #1_000_000;
    failures++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    logic [31:0] r, m, e;
    logic [21:0] p;
    int          v, f, z, t0;
    void'($urandom(32'h200e));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, OFF_CTRL, 0, r); chk("ctrl reset", CTRL_RESET, r);
    bus(1, 8'h10, 32'hffff_ffff, r);
    bus(0, OFF_CTRL, 0, r); chk("ctrl kept", CTRL_RESET, r);
    bus(0, 8'h10, 0, r); chk("unmapped read", 0, r);
    for (int i = 0; i < 12; i++)
    begin
      v = i % 4;
      f = (i >= 8) ? int'($urandom % 2) : 0;
      z = $urandom % 2;
      p = 22'($urandom);
      bus(1, OFF_CTRL, {26'h0, z[0], f[0], 2'h0, v[1:0]}, r);
      bus(1, OFF_POS, {10'h0, p}, r);
      t0 = cyc;
      fork
        i_ssi_ctrl_model.read_msg(len[v], m);
        begin #2000; bus(1, OFF_POS, {10'h0, ~p}, r); end // Late sample ignored
      join
      e = exp_msg(v, p, f[0], z[0], 11'((t0 / TICK_CYCLES) % (TS_WRAP_US + 1)));
      if (v == 3 && 11'(m[10:0] - e[10:0] + 11'h1) <= 11'h2) e[10:0] = m[10:0];
      if (f != 0) e = (e & ~dc[v]) | (m & dc[v]);
      if (f != 0 && v == 0) e[31:24] = crc8(e[23:0]);
      if (f != 0 && v == 1) e[1] = ^e[23:2];
      chk("message", e, m);
      #1000 chk("fault on line", 32'(f), 32'(ssi_data));
      #21000 chk("line released", 1, 32'(ssi_data));
      bus(0, OFF_STAT, 0, r);
      chk("status idle", 0, {30'h0, r[STAT_UPD_BIT], r[STAT_BUSY_BIT]});
      bus(0, OFF_TIME, 0, r);
      chk("time upper", 0, {r[31:TS_W], 11'h000});
    end
    tally_and_finish();
  end
endmodule
